// ---- omsel_pkg.sv ----
// Constants and types shared by the operating-mode selection block
package omsel_pkg;

   // Register port geometry
   localparam int unsigned ADDR_W = 10;
   localparam int unsigned DATA_W = 8;

   // Register offsets
   localparam logic [9:0] ADDR_MODE   = 10'h00b;
   localparam logic [9:0] ADDR_STATUS = 10'h00c;

   // Mode register bit positions
   localparam int unsigned BIT_SPEC_N = 7;
   localparam int unsigned BIT_SEL_B  = 6;
   localparam int unsigned BIT_SEL_A  = 5;
   localparam int unsigned BIT_ESTR   = 4;
   localparam int unsigned BIT_IVIS   = 3;
   localparam int unsigned BIT_EBSWAI = 2;
   localparam int unsigned BIT_EMU_K  = 1;
   localparam int unsigned BIT_EMU_E  = 0;

   // Mode codes {special_mode_n_bit, mode_select_b, mode_select_a}
   localparam logic [2:0] CODE_SPEC_SINGLE = 3'h0;
   localparam logic [2:0] CODE_SPEC_NARROW = 3'h1;
   localparam logic [2:0] CODE_SPEC_PERIPH = 3'h2;
   localparam logic [2:0] CODE_SPEC_WIDE   = 3'h3;
   localparam logic [2:0] CODE_NORM_SINGLE = 3'h4;
   localparam logic [2:0] CODE_NORM_NARROW = 3'h5;
   localparam logic [2:0] CODE_RESERVED    = 3'h6;
   localparam logic [2:0] CODE_NORM_WIDE   = 3'h7;

   // Low two bits that select peripheral (or reserved), single-chip or narrow
   localparam logic [1:0] SEL_PERIPH = 2'h2;
   localparam logic [1:0] SEL_SINGLE = 2'h0;
   localparam logic [1:0] SEL_NARROW = 2'h1;

   // Port function encodings
   localparam logic [1:0] PFUNC_GPIO      = 2'h0;
   localparam logic [1:0] PFUNC_ADDR_DATA = 2'h1;
   localparam logic [1:0] PFUNC_ADDR_ONLY = 2'h2;

   // Reset values of {estr, ivis, ebswai, emk, eme}
   localparam logic [4:0] CTRL_RESET_SPECIAL = 5'h1b;
   localparam logic [4:0] CTRL_RESET_NORMAL  = 5'h10;

   // Capture of strap pins happens once after reset release
   typedef enum logic {PH_CAPTURE, PH_RUN} omsel_phase_t;

endpackage

// ---- omsel_strap_model.sv ----
// Board strap model driving the three mode pins around reset release
`timescale 1ns/1ns
`default_nettype none

module omsel_strap_model (
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic [2:0] strap_code,
   output logic            debug_strap_pin,
   output logic            mode_select_pin_b,
   output logic            mode_select_pin_a
);
   int unsigned run_cnt;

   ////////////////////////////////////////////////////////////////////////////
   // Cycles since release; straps are only guaranteed while reset is low
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         run_cnt <= 0;
      end else if (run_cnt < 5) begin
         run_cnt <= run_cnt + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pins flip later
   // Board no longer holds the straps, so show the inverse to catch recapture
   assign {debug_strap_pin, mode_select_pin_b, mode_select_pin_a} =
      (run_cnt < 5) ? strap_code : ~strap_code;
endmodule

`default_nettype wire

// ---- omsel_top.sv ----
// Operating-mode selection: strap capture, mode register, map and port decode
//
// Contract
// - Capture debug and mode pins at reset release
// - Decode seven modes from three latched bits
// - Reserved code runs as special peripheral
// - Ports A and B function follows mode
// - Port A/B registers unmapped unless single-chip
// - Port E unmapped: peripheral, or expanded with emulation
// - Port K unmapped: peripheral, or expanded with emulation
// - Unimplemented reads return zero
// - Normal modes restrict protected register writes
// - Special modes widen protected register writes
// - Mode bits readable, limited runtime changes
// - Debug monitor available in every mode
// - Special single-chip enters debug monitor at once
// - Mode defaults apply from reset release
// - Special bit writable only while zero, not first
// - Mode-select bits write rules, never peripheral
// - Peripheral mode entered or left only by reset
`timescale 1ns/1ns
`default_nettype none

module omsel_top (
   input  wire logic                              ref_clk,
   input  wire logic                              resetn,
   input  wire logic                              debug_strap_pin,
   input  wire logic                              mode_select_pin_b,
   input  wire logic                              mode_select_pin_a,
   input  wire logic                              debug_release,
   input  wire logic [omsel_pkg::ADDR_W-1:0]      reg_addr,
   input  wire logic [omsel_pkg::DATA_W-1:0]      reg_wdata,
   input  wire logic                              reg_wr,
   input  wire logic                              reg_rd,
   output logic      [omsel_pkg::DATA_W-1:0]      reg_rdata,
   output logic      [2:0]                        mode_latched,
   output logic                                   mode_ready,
   output logic      [1:0]                        port_a_func,
   output logic      [1:0]                        port_b_func,
   output logic                                   port_ab_in_map,
   output logic                                   port_e_in_map,
   output logic                                   port_k_in_map,
   output logic                                   mode_reg_in_map,
   output logic                                   cpu_active,
   output logic                                   debug_monitor_mode,
   output logic                                   debug_available,
   output logic                                   clock_stretch_en,
   output logic                                   internal_visible,
   output logic                                   bus_stop_in_wait
);

   ////////////////////////////////////////////////////////////////////////////
   // Mode decoding helpers

   function automatic logic is_periph(input logic [2:0] code);
      return code[1:0] == omsel_pkg::SEL_PERIPH;
   endfunction

   function automatic logic is_single(input logic [2:0] code);
      return code[1:0] == omsel_pkg::SEL_SINGLE;
   endfunction

   function automatic logic is_expanded(input logic [2:0] code);
      return !is_single(code) && !is_periph(code);
   endfunction

   // Reserved strap code is folded onto special peripheral
   function automatic logic [2:0] fold_code(input logic [2:0] code);
      return (code == omsel_pkg::CODE_RESERVED) ? omsel_pkg::CODE_SPEC_PERIPH : code;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Strap synchronisers; left without reset so they track the pins while
   // reset is held and hold settled levels at the release

   logic [2:0] strap_meta;
   logic [2:0] strap_sync;

   always_ff @(posedge ref_clk) begin
      strap_meta <= {debug_strap_pin, mode_select_pin_b, mode_select_pin_a};
      strap_sync <= strap_meta;
   end

   logic [2:0] strap_code;
   assign strap_code = fold_code(strap_sync);

   ////////////////////////////////////////////////////////////////////////////
   // Mode register state

   omsel_pkg::omsel_phase_t phase;
   logic [2:0]              mode_code;
   logic                    written;
   logic                    clock_stretch_bit;
   logic                    visibility_bit;
   logic                    bus_stop_bit;
   logic                    emulate_port_k_bit;
   logic                    emulate_port_e_bit;
   logic                    dbg_active;

   logic                    special_mode_n_bit;
   assign special_mode_n_bit = mode_code[2];

   logic mode_wr_hit;
   assign mode_wr_hit = reg_wr && (reg_addr == omsel_pkg::ADDR_MODE)
                        && (phase == omsel_pkg::PH_RUN) && !is_periph(mode_code);

   logic [2:0] next_mode_code;
   logic       next_clock_stretch;
   logic       next_visibility;
   logic       next_bus_stop;
   logic       next_emulate_k;
   logic       next_emulate_e;

   // Write filter; first write in special modes only touches the stretch bit
   always_comb begin
      next_mode_code     = mode_code;
      next_clock_stretch = clock_stretch_bit;
      next_visibility    = visibility_bit;
      next_bus_stop      = bus_stop_bit;
      next_emulate_k     = emulate_port_k_bit;
      next_emulate_e     = emulate_port_e_bit;
      if (mode_wr_hit) begin
         if (!special_mode_n_bit) begin
            next_clock_stretch = reg_wdata[omsel_pkg::BIT_ESTR];
            if (written) begin
               next_mode_code[2] = reg_wdata[omsel_pkg::BIT_SPEC_N];
               if (reg_wdata[omsel_pkg::BIT_SEL_B:omsel_pkg::BIT_SEL_A]
                   != omsel_pkg::SEL_PERIPH) begin
                  next_mode_code[1:0] = reg_wdata[omsel_pkg::BIT_SEL_B:omsel_pkg::BIT_SEL_A];
               end
               next_visibility = reg_wdata[omsel_pkg::BIT_IVIS];
               next_emulate_k  = reg_wdata[omsel_pkg::BIT_EMU_K];
               next_emulate_e  = reg_wdata[omsel_pkg::BIT_EMU_E];
            end
         end else begin
            if (!written) begin
               if (reg_wdata[omsel_pkg::BIT_SEL_B:omsel_pkg::BIT_SEL_A]
                   != omsel_pkg::SEL_PERIPH) begin
                  next_mode_code[1:0] = reg_wdata[omsel_pkg::BIT_SEL_B:omsel_pkg::BIT_SEL_A];
               end
               next_clock_stretch = reg_wdata[omsel_pkg::BIT_ESTR];
               next_visibility    = reg_wdata[omsel_pkg::BIT_IVIS];
               next_emulate_k     = reg_wdata[omsel_pkg::BIT_EMU_K];
               next_emulate_e     = reg_wdata[omsel_pkg::BIT_EMU_E];
            end
            next_bus_stop = reg_wdata[omsel_pkg::BIT_EBSWAI];
         end
      end
      // Stretch is required to demultiplex the expanded bus
      if (is_expanded(next_mode_code)) begin
         next_clock_stretch = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         phase <= omsel_pkg::PH_CAPTURE;
      end else begin
         phase <= omsel_pkg::PH_RUN;
      end
   end

   // code held between resets, changed only by filtered writes
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         mode_code <= omsel_pkg::CODE_SPEC_SINGLE;
      end else if (phase == omsel_pkg::PH_CAPTURE) begin
         mode_code <= strap_code;
      end else begin
         mode_code <= next_mode_code;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         {clock_stretch_bit, visibility_bit, bus_stop_bit,
          emulate_port_k_bit, emulate_port_e_bit} <= omsel_pkg::CTRL_RESET_SPECIAL;
      end else if (phase == omsel_pkg::PH_CAPTURE) begin
         {clock_stretch_bit, visibility_bit, bus_stop_bit,
          emulate_port_k_bit, emulate_port_e_bit} <= strap_code[2]
            ? omsel_pkg::CTRL_RESET_NORMAL : omsel_pkg::CTRL_RESET_SPECIAL;
      end else begin
         clock_stretch_bit  <= next_clock_stretch;
         visibility_bit     <= next_visibility;
         bus_stop_bit       <= next_bus_stop;
         emulate_port_k_bit <= next_emulate_k;
         emulate_port_e_bit <= next_emulate_e;
      end
   end

   // First-write tracker shared by write-once and ignore-first fields
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         written <= 1'b0;
      end else if (mode_wr_hit) begin
         written <= 1'b1;
      end
   end

   // debug monitor active out of reset only for special single-chip straps
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         dbg_active <= 1'b0;
      end else if (phase == omsel_pkg::PH_CAPTURE) begin
         dbg_active <= (strap_code == omsel_pkg::CODE_SPEC_SINGLE);
      end else if (debug_release) begin
         dbg_active <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered decode outputs; one cycle behind the code, which matters
   // in the cycle after the strap capture and in the cycle after a write

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         mode_latched       <= omsel_pkg::CODE_SPEC_SINGLE;
         mode_ready         <= 1'b0;
         port_a_func        <= omsel_pkg::PFUNC_GPIO;
         port_b_func        <= omsel_pkg::PFUNC_GPIO;
         port_ab_in_map     <= 1'b1;
         port_e_in_map      <= 1'b1;
         port_k_in_map      <= 1'b1;
         mode_reg_in_map    <= 1'b1;
         cpu_active         <= 1'b0;
         debug_monitor_mode <= 1'b0;
         debug_available    <= 1'b0;
         clock_stretch_en   <= 1'b1;
         internal_visible   <= 1'b0;
         bus_stop_in_wait   <= 1'b0;
      end else begin
         mode_latched <= mode_code;
         mode_ready   <= (phase == omsel_pkg::PH_RUN);
         port_a_func  <= is_single(mode_code) ? omsel_pkg::PFUNC_GPIO
                                              : omsel_pkg::PFUNC_ADDR_DATA;
         port_b_func  <= is_single(mode_code) ? omsel_pkg::PFUNC_GPIO
                        : (mode_code[1:0] == omsel_pkg::SEL_NARROW)
                          ? omsel_pkg::PFUNC_ADDR_ONLY : omsel_pkg::PFUNC_ADDR_DATA;
         port_ab_in_map <= is_single(mode_code);
         port_e_in_map  <= !(is_periph(mode_code)
                             || (is_expanded(mode_code) && emulate_port_e_bit));
         port_k_in_map  <= !(is_periph(mode_code)
                             || (is_expanded(mode_code) && emulate_port_k_bit));
         mode_reg_in_map <= !is_periph(mode_code);
         // CPU held idle in peripheral mode
         cpu_active         <= (phase == omsel_pkg::PH_RUN) && !is_periph(mode_code);
         debug_monitor_mode <= dbg_active;
         debug_available    <= (phase == omsel_pkg::PH_RUN);
         clock_stretch_en   <= clock_stretch_bit;
         internal_visible   <= visibility_bit && !is_single(mode_code);
         bus_stop_in_wait   <= bus_stop_bit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read port; data stands the cycle after the strobe only

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= '0;
         if (reg_addr == omsel_pkg::ADDR_MODE && !is_periph(mode_code)) begin
            reg_rdata <= {mode_code, clock_stretch_bit, visibility_bit,
                          bus_stop_bit, emulate_port_k_bit, emulate_port_e_bit};
         end else if (reg_addr == omsel_pkg::ADDR_STATUS) begin
            reg_rdata <= {phase == omsel_pkg::PH_RUN, dbg_active,
                          is_single(mode_code), port_e_in_map, port_k_in_map,
                          !is_periph(mode_code), written, 1'b0};
         end
      end else begin
         reg_rdata <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   sequence s_capture;
      phase == omsel_pkg::PH_CAPTURE;
   endsequence

   sequence s_first_special_write;
      mode_wr_hit && !special_mode_n_bit && !written;
   endsequence

   a_strap_capture: assert property (s_capture |=> mode_code == fold_code($past(strap_sync)))
      else $error("Mode code differs from captured straps");

   a_reserved_fold: assert property (
      (s_capture and (strap_sync == omsel_pkg::CODE_RESERVED))
      |=> mode_code == omsel_pkg::CODE_SPEC_PERIPH ##1 !cpu_active)
      else $error("Reserved straps not forced to peripheral");

   a_port_a_use: assert property (
      is_single(mode_code) |=> port_a_func == omsel_pkg::PFUNC_GPIO && port_ab_in_map)
      else $error("Single-chip port use wrong");

   a_narrow_port_b: assert property (
      mode_code[1:0] == omsel_pkg::SEL_NARROW
      |=> port_b_func == omsel_pkg::PFUNC_ADDR_ONLY && !port_ab_in_map)
      else $error("Narrow mode port B decode wrong");

   a_port_e_map: assert property (
      is_expanded(mode_code) && emulate_port_e_bit |=> !port_e_in_map)
      else $error("Port E left in map while emulated");

   a_port_k_map: assert property (
      is_periph(mode_code) |=> !port_k_in_map && !port_e_in_map)
      else $error("Port K or E in map in peripheral mode");

   a_debug_at_reset: assert property (
      (s_capture and (strap_code == omsel_pkg::CODE_SPEC_SINGLE && !debug_release))
      |=> ##1 debug_monitor_mode)
      else $error("Debug monitor not active after special single-chip reset");

   a_normal_stays: assert property (
      phase == omsel_pkg::PH_RUN && special_mode_n_bit |=> special_mode_n_bit)
      else $error("Normal mode returned to special");

   a_first_ignored: assert property (
      s_first_special_write |=> mode_code == $past(mode_code)
                                && visibility_bit == $past(visibility_bit))
      else $error("First special write was not ignored");

   a_periph_locked: assert property (
      phase == omsel_pkg::PH_RUN && is_periph(mode_code)
      |=> is_periph(mode_code) [*3])
      else $error("Peripheral mode left without reset");

   a_mode_readback: assert property (
      reg_rd && reg_addr == omsel_pkg::ADDR_MODE && !is_periph(mode_code)
      |=> reg_rdata[omsel_pkg::BIT_SPEC_N:omsel_pkg::BIT_SEL_A] == $past(mode_code))
      else $error("Mode readback mismatch");

   a_normal_once: assert property (
      mode_wr_hit && special_mode_n_bit && written
      |=> mode_code == $past(mode_code) && emulate_port_k_bit == $past(emulate_port_k_bit))
      else $error("Normal write-once field changed twice");

endmodule

`default_nettype wire

// ---- test_operating_mode_select.sv ----
// Self-checking bench: strap sweep, register write rules and mode decode
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module test_operating_mode_select;
   logic       ref_clk, resetn, debug_release, reg_wr, reg_rd;
   logic [9:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, q, lfsr;
   logic [2:0] strap_code, mode_latched;
   logic [1:0] port_a_func, port_b_func;
   logic       debug_strap_pin, mode_select_pin_b, mode_select_pin_a, mode_ready;
   logic       port_ab_in_map, port_e_in_map, port_k_in_map, mode_reg_in_map;
   logic       cpu_active, debug_monitor_mode, debug_available;
   logic       clock_stretch_en, internal_visible, bus_stop_in_wait;
   int         m_code, m_ctrl, m_wr, m_dbg, n_fail, cmp_count, cycles;

   omsel_strap_model omsel_strap_model_inst (.ref_clk, .resetn, .strap_code,
      .debug_strap_pin, .mode_select_pin_b, .mode_select_pin_a);

   omsel_top omsel_top_inst (.ref_clk, .resetn, .debug_strap_pin, .mode_select_pin_b,
      .mode_select_pin_a, .debug_release, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .mode_latched, .mode_ready, .port_a_func, .port_b_func,
      .port_ab_in_map, .port_e_in_map, .port_k_in_map, .mode_reg_in_map, .cpu_active,
      .debug_monitor_mode, .debug_available, .clock_stretch_en, .internal_visible,
      .bus_stop_in_wait);

   ////////////////////////////////////////////////////////////////////////////
   // Reference model helpers
   function automatic logic [7:0] lfsr_next(logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic in_e();
      return !(m_code == 2 || (m_code % 4 != 0 && m_ctrl[0]));
   endfunction
   function automatic logic in_k();
      return !(m_code == 2 || (m_code % 4 != 0 && m_ctrl[1]));
   endfunction
   function automatic logic [7:0] m_mode();
      return (m_code == 2) ? 8'h00 : {m_code[2:0], m_ctrl[4:0]};
   endfunction

   // Write rules differ by mode; peripheral mode ignores every write
   task automatic m_write(input int d);
      if (m_code == 2) return;
      if (m_code < 4) begin
         m_ctrl[4] = d[4];
         if (m_wr != 0) begin
            m_code = {d[7], (d[6:5] == 2'h2) ? m_code[1:0] : d[6:5]};
            m_ctrl = {m_ctrl[4], d[3], m_ctrl[2], d[1:0]};
         end
      end else begin
         m_ctrl[2] = d[2];
         if (m_wr == 0) begin
            m_code[1:0] = (d[6:5] == 2'h2) ? m_code[1:0] : d[6:5];
            m_ctrl = {d[4:3], m_ctrl[2], d[1:0]};
         end
      end
      if (m_code % 4 != 0) m_ctrl[4] = 1;
      m_wr = 1;
   endtask

   task automatic chk_out();
      int sel;
      sel = m_code % 4;
      `CHK(mode_latched, 3'(m_code))
      `CHK(port_a_func, (sel == 0) ? 2'h0 : 2'h1)
      `CHK(port_b_func, (sel == 0) ? 2'h0 : (sel == 1) ? 2'h2 : 2'h1)
      `CHK(port_ab_in_map, sel == 0)
      `CHK(port_e_in_map, in_e())
      `CHK(port_k_in_map, in_k())
      `CHK({mode_reg_in_map, cpu_active}, {2{m_code != 2}})
      `CHK({mode_ready, debug_available}, 2'h3)
      `CHK(clock_stretch_en, m_ctrl[4])
      `CHK(internal_visible, m_ctrl[3] && sel != 0)
      `CHK(bus_stop_in_wait, m_ctrl[2])
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Bus master: optional write, then a read back to back; starts after an edge
   task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d,
                       output logic [7:0] r);
      reg_addr <= a;
      reg_wdata <= d;
      if (w) begin
         reg_wr <= 1'h1;
         @(posedge ref_clk);
         reg_wr <= 1'h0;
      end
      reg_rd <= 1'h1;
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      @(negedge ref_clk);
      r = reg_rdata;
      @(negedge ref_clk);
      `CHK(reg_rdata, 8'h00)
      @(posedge ref_clk);
   endtask

   task automatic final_report();
      if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial begin
      ref_clk = 1'h0;
      forever #2 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         final_report();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Every strap code through reset, then register traffic in that mode
   initial begin
      {resetn, debug_release, reg_wr, reg_rd} = 4'h0;
      {reg_addr, reg_wdata, strap_code} = 21'h0;
      lfsr = 8'h62;
      for (int c = 0; c < 8; c++) begin
         @(posedge ref_clk);
         resetn <= 1'h0;
         strap_code <= 3'(c);
         repeat (8) @(posedge ref_clk);
         @(negedge ref_clk);
         `CHK({cpu_active, port_e_in_map, clock_stretch_en}, 3'h3)
         @(posedge ref_clk);
         resetn <= 1'h1;
         m_code = (c == 6) ? 2 : c;
         m_ctrl = (c < 4 || c == 6) ? 5'h1b : 5'h10;
         m_wr = 0;
         m_dbg = (c == 0);
         repeat (3) @(posedge ref_clk);
         @(negedge ref_clk);
         chk_out();
         `CHK(debug_monitor_mode, 1'(m_dbg))
         @(posedge ref_clk);
         lfsr = lfsr_next(lfsr);
         xfer(1'h1, omsel_pkg::ADDR_STATUS, lfsr, q);
         `CHK(q, {1'h1, 1'(m_dbg), m_code % 4 == 0, in_e(), in_k(), m_code != 2, 2'h0})
         xfer(1'h0, 10'h3ff, 8'h00, q);
         `CHK(q, 8'h00)
         xfer(1'h0, omsel_pkg::ADDR_MODE, 8'h00, q);
         `CHK(q, m_mode())
         debug_release <= 1'h1;
         @(posedge ref_clk);
         debug_release <= 1'h0;
         repeat (3) @(posedge ref_clk);
         @(negedge ref_clk);
         `CHK(debug_monitor_mode, 1'h0)
         @(posedge ref_clk);
         repeat (4) begin
            lfsr = lfsr_next(lfsr);
            m_write(lfsr);
            xfer(1'h1, omsel_pkg::ADDR_MODE, lfsr, q);
            `CHK(q, m_mode())
            @(negedge ref_clk);
            chk_out();
            @(posedge ref_clk);
         end
      end
      final_report();
   end
endmodule

`default_nettype wire
